// ### pbi_port.v
`include "pbi_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module pbi_port #(
    parameter DATA_W = `PBI_DATA_W,
    parameter DEPTH = `PBI_FIFO_DEPTH,
    parameter AW = 4,
    parameter ACK_CYC = `PBI_ACK_CYC
) (
    input wire CORE_CLK,
    input wire RST,
    input wire INPUT_STROBE_N,
    input wire IN_DATA_BIT_0,
    input wire IN_DATA_BIT_1,
    input wire IN_DATA_BIT_2,
    input wire IN_DATA_BIT_3,
    input wire IN_DATA_BIT_4,
    input wire IN_DATA_BIT_5,
    input wire IN_DATA_BIT_6,
    input wire IN_DATA_BIT_7,
    output reg BUSY,
    output reg ACK_N,
    output reg BYTE_VALID,
    input wire BYTE_READY,
    output reg [DATA_W-1:0] BYTE_DATA
);
    localparam S_IDLE = 4'b0001;
    localparam S_WAIT = 4'b0010;
    localparam S_ACK = 4'b0100;
    localparam S_DONE = 4'b1000;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [DATA_W-1:0] hold_reg;
    reg [`PBI_ACK_CNT_W-1:0] cnt_reg;
    reg strobe_d_reg;
    wire [7:0] pins;
    wire strobe_fall;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    wire push;
    wire out_take;
    assign pins = {IN_DATA_BIT_7, IN_DATA_BIT_6, IN_DATA_BIT_5,
        IN_DATA_BIT_4, IN_DATA_BIT_3, IN_DATA_BIT_2, IN_DATA_BIT_1,
        IN_DATA_BIT_0};
    // Falling strobe edge starts a byte
    assign strobe_fall = strobe_d_reg & ~INPUT_STROBE_N;
    assign push = (state_reg == S_WAIT) & fifo_in_ready;
    assign out_take = ~BYTE_VALID | BYTE_READY;
    // Handshake sequencer
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (strobe_fall)
                begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT:
            begin
                if (fifo_in_ready)
                begin
                    state_next = S_ACK;
                end
            end
            S_ACK:
            begin
                if (cnt_reg == ACK_CYC[`PBI_ACK_CNT_W-1:0] - 8'h01)
                begin
                    state_next = S_DONE;
                end
            end
            S_DONE:
            begin
                // Busy is already low here, so a strobe must count
                if (strobe_fall)
                begin
                    state_next = S_WAIT;
                end
                else
                begin
                    state_next = S_IDLE;
                end
            end
            default:
            begin
                state_next = S_IDLE;
            end
        endcase
    end
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= S_IDLE;
            hold_reg <= `PBI_DATA_RST;
            cnt_reg <= `PBI_ACK_CNT_RST;
            strobe_d_reg <= 1'b1;
            BUSY <= 1'b0;
            ACK_N <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            strobe_d_reg <= INPUT_STROBE_N;
            // Capture on the falling strobe edge only, and only when not busy
            if ((state_reg == S_IDLE || state_reg == S_DONE) && strobe_fall)
            begin
                hold_reg <= pins;
            end
            if (state_reg == S_ACK)
            begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            else
            begin
                cnt_reg <= `PBI_ACK_CNT_RST;
            end
            // Busy covers whole transfer until ack release
            BUSY <= (state_next != S_IDLE) && (state_next != S_DONE)
                || (state_next == S_DONE && state_reg != S_ACK);
            ACK_N <= (state_next != S_ACK);
        end
    end
    pbi_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(hold_reg),
        .out_valid(fifo_out_valid),
        .out_ready(out_take),
        .out_data(fifo_out_data)
    );
    // Registered user output stage
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            BYTE_VALID <= 1'b0;
            BYTE_DATA <= `PBI_DATA_RST;
        end
        else if (out_take)
        begin
            BYTE_VALID <= fifo_out_valid;
            BYTE_DATA <= fifo_out_data;
        end
    end
endmodule
`default_nettype wire

// ### pbi_defs.vh
// Contract
// - Device receives bytes over eight data lines driven by the host.
// - Host strobe is the timing reference for reading the data lines.
// - Device drives busy high when it detects an active strobe.
// - Further strobes are ignored while busy is high.
// - After reading the byte, device issues an acknowledge pulse.
// - Busy drops at acknowledge rising edge; device then awaits next strobe.
// - Busy shows whether a byte can be accepted; host waits while high.
`ifndef PBI_DEFS_VH
`define PBI_DEFS_VH
`define PBI_DATA_W 8
`define PBI_FIFO_DEPTH 16
`define PBI_ACK_NS 1000
`define PBI_CLK_NS 10
`define PBI_ACK_CYC (`PBI_ACK_NS / `PBI_CLK_NS)
`define PBI_ACK_CNT_W 8
`define PBI_ACK_CNT_RST 8'h00
`define PBI_DATA_RST 8'h00
`endif

// ### pbi_mem.v
`timescale 1ns/1ps
`default_nettype none
module pbi_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // Registered read, held until the next fetch
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ### pbi_fifo.v
`timescale 1ns/1ps
`default_nettype none
module pbi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] count;
    wire full;
    wire empty;
    wire push;
    wire pop;
    wire [WIDTH-1:0] mem_q;
    assign count = wr_ptr_reg - rd_ptr_reg;
    assign full = (count == DEPTH[AW:0]);
    assign empty = (count == {(AW+1){1'b0}});
    assign in_ready = ~full;
    assign push = in_valid & ~full;
    // Fetch when output slot free or being taken
    assign pop = ~empty & (~out_valid | out_ready);
    assign out_data = mem_q;
    pbi_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk(clk),
        .wr_en(push),
        .wr_addr(wr_ptr_reg[AW-1:0]),
        .wr_data(in_data),
        .rd_en(pop),
        .rd_addr(rd_ptr_reg[AW-1:0]),
        .rd_data(mem_q)
    );
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### pbi_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbi_checker #(
    parameter ACK_CYC = 100
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic INPUT_STROBE_N,
    input wire logic BUSY,
    input wire logic ACK_N,
    input wire logic BYTE_VALID,
    input wire logic BYTE_READY,
    input wire logic [7:0] BYTE_DATA
);
    logic [7:0] cnt_reg;
    always @(posedge CORE_CLK or posedge RST)
        cnt_reg <= RST ? 8'h00 : (ACK_N ? 8'h00 : cnt_reg + 8'h01);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_hold;
        BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_DATA);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_cause;
        $rose(BUSY) |-> !$past(INPUT_STROBE_N) && $past(INPUT_STROBE_N, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("busy no strobe");
    property p_take;
        $fell(INPUT_STROBE_N) && !BUSY |=> BUSY;
    endproperty
    a_take: assert property (p_take) else $error("busy missing");
    property p_stay;
        BUSY && ACK_N |=> BUSY;
    endproperty
    a_stay: assert property (p_stay) else $error("busy dropped");
    property p_ack;
        $rose(BUSY) |-> ##[1:300] !ACK_N;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_rel;
        $fell(BUSY) |-> $rose(ACK_N);
    endproperty
    a_rel: assert property (p_rel) else $error("busy fell early");
    property p_show;
        !ACK_N |-> BUSY;
    endproperty
    a_show: assert property (p_show) else $error("ack without busy");
    property p_width;
        $rose(ACK_N) |-> cnt_reg == ACK_CYC;
    endproperty
    a_width: assert property (p_width) else $error("ack width");
    c_take: cover property ($rose(BUSY));
    c_full: cover property ((BUSY && ACK_N) [*8]);
    c_stall: cover property (BYTE_VALID && !BYTE_READY);
endmodule
bind pbi_port pbi_checker #(.ACK_CYC(ACK_CYC)) chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .INPUT_STROBE_N(INPUT_STROBE_N),
    .BUSY(BUSY), .ACK_N(ACK_N), .BYTE_VALID(BYTE_VALID),
    .BYTE_READY(BYTE_READY), .BYTE_DATA(BYTE_DATA));
`default_nettype wire

// ### pbi_host.sv
`timescale 1ns/1ps
`default_nettype none
module pbi_host (
    input wire logic clk,
    input wire logic busy,
    output logic strb_n,
    output logic [7:0] data
);
    initial strb_n = 1'b1;
    initial data = 8'h00;
    // Pushy sends strobe regardless of busy
    task send(input logic [7:0] b, input logic pushy);
        if (!pushy)
        begin
            #1;
            while (busy !== 1'b0)
            begin
                @(posedge clk);
                #1;
            end
            @(posedge clk);
        end
        strb_n <= 1'b0;
        data <= b;
        repeat (2) @(posedge clk);
        strb_n <= 1'b1;
        @(posedge clk);
        data <= ~b;
    endtask
endmodule
`default_nettype wire

// ### tb_parallel_byte_input_handshake.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
        failures++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end
module tb_parallel_byte_input_handshake;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rdy = 1'b0;
    logic busy, ack_n, vld, strb_n;
    logic [7:0] hd, bd;
    logic [7:0] exp_q[$];
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    pbi_host host (.clk(clk), .busy(busy), .strb_n(strb_n), .data(hd));
    pbi_port #(.ACK_CYC(4)) dut (.CORE_CLK(clk), .RST(rst),
        .INPUT_STROBE_N(strb_n), .IN_DATA_BIT_0(hd[0]), .IN_DATA_BIT_1(hd[1]),
        .IN_DATA_BIT_2(hd[2]), .IN_DATA_BIT_3(hd[3]), .IN_DATA_BIT_4(hd[4]),
        .IN_DATA_BIT_5(hd[5]), .IN_DATA_BIT_6(hd[6]), .IN_DATA_BIT_7(hd[7]),
        .BUSY(busy), .ACK_N(ack_n), .BYTE_VALID(vld), .BYTE_READY(rdy),
        .BYTE_DATA(bd));
    task print_verdict;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task drain(input int n);
        logic [7:0] e;
        @(posedge clk);
        rdy <= 1'b1;
        while (n > 0)
        begin
            @(posedge clk);
            if (vld === 1'b1)
            begin
                e = exp_q.pop_front();
                `CHK("byte", e, bd)
                n--;
            end
        end
        @(posedge clk);
        rdy <= 1'b0;
    endtask
    task t_bits;
        for (int i = 0; i < 8; i++)
        begin
            host.send(8'h01 << i, 1'b0);
            exp_q.push_back(8'h01 << i);
        end
        drain(8);
    endtask
    // Strobe during busy must leave no byte behind
    task t_ignore;
        host.send(8'h3C, 1'b0);
        host.send(8'hC3, 1'b1);
        host.send(8'h5A, 1'b0);
        exp_q.push_back(8'h3C);
        exp_q.push_back(8'h5A);
        drain(2);
    endtask
    task t_full;
        for (int i = 0; i < 19; i++)
        begin
            host.send(8'h10 + i, 1'b0);
            exp_q.push_back(8'h10 + i);
        end
        repeat (20) @(posedge clk);
        #1;
        `CHK("busy", 1'b1, busy)
        `CHK("ack", 1'b1, ack_n)
        drain(19);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_bits;
        t_ignore;
        t_full;
        print_verdict;
    end
endmodule
`default_nettype wire
